// ===== rtl/mcu_exec_defines.svh
// timing counts, field positions and reset values for the execution block
`ifndef MCU_EXEC_DEFINES_SVH
`define MCU_EXEC_DEFINES_SVH
`define CLK_PERIOD_NS      50
`define SYS_CLK_PERIOD_NS  50
`define CLKS_PER_CYCLE     4
`define PHASE_LAST         2'h3
`define PC_W               11
`define STACK_DEPTH        6
`define PC_LOW_ADDR        8'h02
`define LAST_PAGE          3'h7
`define BYTE_ZERO          8'h00
`define ACC_RESET          8'h00
`define WDT_RESET          8'h00
`define PC_RESET           11'h000
`endif

// ===== rtl/mcu_exec_pkg.sv
// operation codes of the execution block
package mcu_exec_pkg;
  typedef enum logic [5:0] {
    op_nop, op_jump, op_call, op_return, op_return_imm, op_return_from_interrupt,
    op_skip_if_zero, op_skip_if_zero_move, op_skip_if_bit_clear, op_skip_if_bit_set,
    op_increment_skip_zero, op_decrement_skip_zero,
    op_increment_skip_zero_to_accumulator, op_decrement_skip_zero_to_accumulator,
    op_table_read_current_page, op_table_read_last_page,
    op_add, op_add_imm, op_add_carry, op_add_to_memory, op_add_carry_to_memory,
    op_and, op_and_imm, op_and_to_memory,
    op_clear_byte, op_clear_bit, op_set_byte, op_swap, op_nibble_swap_to_accumulator,
    op_clear_watchdog, op_watchdog_preclear_first, op_watchdog_preclear_second, op_halt
  } op_t;
  typedef enum {st_idle, st_run, st_halted} exec_state_t;
endpackage : mcu_exec_pkg

// ===== rtl/mcu_branch_misc_exec.sv
// execution core for branch, skip, table-read, clear/swap, watchdog and add/and ops
`timescale 1ns/10ps
`include "mcu_exec_defines.svh"
// Notes on behaviour
// - taken skip adds one four-clock cycle
// - program-counter-low write adds one cycle
// - skip on zero byte or selected bit
// - zero-move skip copies byte to accumulator
// - inc/dec skip writes memory, both penalties
// - accumulator inc/dec skip leaves memory alone
// - call pushes next address, two cycles
// - returns take two cycles; immediate loads accumulator
// - interrupt return pops and enables interrupts
// - table read: low to memory, high latch
// - add-with-carry updates four flags
// - memory-destination adds store into memory
// - immediate add updates four flags
// - and instructions touch only zero flag
// - clear byte or bit, flags untouched
// - watchdog clear zeroes count and flags
// - pre-clear pair clears flags when completed
// - lone pre-clear only records itself
// - nibble swap; accumulator form one cycle
// - halt stops, clears watchdog, sets power-down
module mcu_branch_misc_exec
  import mcu_exec_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   instr_valid,
  input  mcu_exec_pkg::op_t           instr_op,
  input  wire logic [7:0]             instr_mem_addr,
  input  wire logic [2:0]             instr_bit,
  input  wire logic [7:0]             instr_imm,
  input  wire logic [`PC_W-1:0]       instr_target,
  input  wire logic [7:0]             mem_rdata,
  input  wire logic [15:0]            rom_rdata,
  input  wire logic                   wake_up,
  output logic                        instr_ready,
  output logic [7:0]                  mem_addr,
  output logic [7:0]                  mem_wdata,
  output logic                        mem_we,
  output logic [`PC_W-1:0]            rom_addr,
  output logic [`PC_W-1:0]            program_counter,
  output logic [7:0]                  accumulator,
  output logic [7:0]                  table_high_latch,
  output logic                        overflow_flag,
  output logic                        zero_flag,
  output logic                        half_carry_flag,
  output logic                        carry_flag,
  output logic                        watchdog_timeout_flag,
  output logic                        power_down_flag,
  output logic                        global_interrupt_enable,
  output logic [7:0]                  watchdog_counter,
  output logic                        prescaler_clear,
  output logic                        halted,
  output logic                        stack_overflow
);
  // adder giving sum plus overflow, half-carry and carry
  function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    add8 = {(a[7] == b[7]) && (s[7] != a[7]), h[4], s[8], s[7:0]};
  endfunction : add8
  // latched instruction fields
  op_t               op;
  logic [7:0]        imm;
  logic [2:0]        bsel;
  logic [`PC_W-1:0]  target;
  logic [1:0]        phase;
  logic [1:0]        cycles_left;
  logic              preclear_first_seen;
  logic              preclear_second_seen;
  logic [`PC_W-1:0]  stack [`STACK_DEPTH];
  logic [2:0]        sp;
  exec_state_t       state;
  logic [10:0]       sum;
  logic [7:0]        operand_b;
  logic              is_skip_op;
  logic              skip_taken;
  logic [7:0]        incdec;
  logic              writes_pcl;
  logic              cycle_end;
  logic              start;
  // combinational decode of the latched operation
  always_comb begin
    operand_b = (op == op_add_imm || op == op_and_imm) ? imm : mem_rdata;
    sum = add8(accumulator, operand_b,
               (op == op_add_carry || op == op_add_carry_to_memory) ? carry_flag : 1'b0);
    incdec = (op == op_increment_skip_zero || op == op_increment_skip_zero_to_accumulator)
             ? mem_rdata + 8'h01 : mem_rdata - 8'h01;
    is_skip_op = op inside {op_skip_if_zero, op_skip_if_zero_move, op_skip_if_bit_clear,
                            op_skip_if_bit_set, op_increment_skip_zero,
                            op_decrement_skip_zero, op_increment_skip_zero_to_accumulator,
                            op_decrement_skip_zero_to_accumulator};
    unique case (op)
      op_skip_if_zero, op_skip_if_zero_move: skip_taken = (mem_rdata == `BYTE_ZERO);
      op_skip_if_bit_clear: skip_taken = !mem_rdata[bsel];
      op_skip_if_bit_set:   skip_taken = mem_rdata[bsel];
      op_increment_skip_zero, op_decrement_skip_zero,
      op_increment_skip_zero_to_accumulator,
      op_decrement_skip_zero_to_accumulator: skip_taken = (incdec == `BYTE_ZERO);
      default: skip_taken = 1'b0;
    endcase
    // memory-writing ops aimed at the program-counter low byte cost a cycle
    writes_pcl = (mem_addr == `PC_LOW_ADDR) &&
                 (op inside {op_increment_skip_zero, op_decrement_skip_zero,
                             op_add_to_memory, op_add_carry_to_memory, op_and_to_memory,
                             op_clear_byte, op_clear_bit, op_set_byte, op_swap,
                             op_table_read_current_page, op_table_read_last_page});
    cycle_end = (phase == `PHASE_LAST);
    start = instr_valid && instr_ready;
  end
  // sequencer: four system clocks per instruction cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state        <= st_idle;
      phase        <= 2'h0;
      cycles_left  <= 2'h0;
      instr_ready  <= 1'b0;
      op <= op_nop;
      imm <= 8'h00;
      bsel <= 3'h0;
      target <= `PC_RESET;
      mem_addr <= 8'h00;
    end else begin
      unique case (state)
        st_idle: begin
          instr_ready <= 1'b1;
          if (start) begin
            op <= instr_op;
            imm <= instr_imm;
            bsel <= instr_bit;
            target <= instr_target;
            mem_addr <= instr_mem_addr;
            phase <= 2'h0;
            instr_ready <= 1'b0;
            cycles_left <= (instr_op inside {op_jump, op_call, op_return, op_return_imm,
                            op_return_from_interrupt, op_table_read_current_page,
                            op_table_read_last_page}) ? 2'h1 : 2'h0;
            state <= st_run;
          end
        end
        st_run: begin
          phase <= phase + 2'h1;
          if (cycle_end) begin
            if (cycles_left != 2'h0) begin
              cycles_left <= cycles_left - 2'h1;
            end else if (op == op_halt) begin
              state <= st_halted;
            end else if (is_skip_op && skip_taken) begin
              op <= op_nop;
              cycles_left <= (writes_pcl) ? 2'h1 : 2'h0;
            end else if (writes_pcl) begin
              op <= op_nop;
            end else begin
              state <= st_idle;
              instr_ready <= 1'b1;
            end
          end
        end
        st_halted: begin
          if (wake_up) begin
            state <= st_idle;
            instr_ready <= 1'b1;
          end
        end
      endcase
    end
  end
  // effects on the last clock of the final cycle; a skipped slot is a nop
  logic first_end;
  assign first_end = (state == st_run) && cycle_end && (op != op_nop) && (cycles_left == 2'h0);
  // accumulator and arithmetic flags
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      accumulator <= `ACC_RESET;
      overflow_flag <= 1'b0;
      zero_flag <= 1'b0;
      half_carry_flag <= 1'b0;
      carry_flag <= 1'b0;
    end else if (first_end) begin
      unique case (op)
        op_add, op_add_imm, op_add_carry, op_add_to_memory, op_add_carry_to_memory: begin
          if (!(op inside {op_add_to_memory, op_add_carry_to_memory}))
            accumulator <= sum[7:0];
          overflow_flag   <= sum[10];
          half_carry_flag <= sum[9];
          carry_flag      <= sum[8];
          zero_flag       <= (sum[7:0] == `BYTE_ZERO);
        end
        op_and, op_and_imm, op_and_to_memory: begin
          if (op != op_and_to_memory)
            accumulator <= accumulator & operand_b;
          zero_flag <= ((accumulator & operand_b) == `BYTE_ZERO);
        end
        op_skip_if_zero_move: accumulator <= mem_rdata;
        op_increment_skip_zero_to_accumulator,
        op_decrement_skip_zero_to_accumulator: accumulator <= incdec;
        op_return_imm: accumulator <= imm;
        op_nibble_swap_to_accumulator: accumulator <= {mem_rdata[3:0], mem_rdata[7:4]};
        default: ;
      endcase
    end
  end
  // data memory write port
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mem_we <= 1'b0;
      mem_wdata <= 8'h00;
      table_high_latch <= 8'h00;
    end else begin
      mem_we <= 1'b0;
      if (first_end) begin
        unique case (op)
          op_increment_skip_zero, op_decrement_skip_zero: begin
            mem_we <= 1'b1;
            mem_wdata <= incdec;
          end
          op_add_to_memory, op_add_carry_to_memory: begin
            mem_we <= 1'b1;
            mem_wdata <= sum[7:0];
          end
          op_and_to_memory: begin
            mem_we <= 1'b1;
            mem_wdata <= accumulator & mem_rdata;
          end
          op_clear_byte, op_set_byte: begin
            mem_we <= 1'b1;
            mem_wdata <= (op == op_set_byte) ? 8'hff : `BYTE_ZERO;
          end
          op_clear_bit: begin
            mem_we <= 1'b1;
            mem_wdata <= mem_rdata & ~(8'h01 << bsel);
          end
          op_swap: begin
            mem_we <= 1'b1;
            mem_wdata <= {mem_rdata[3:0], mem_rdata[7:4]};
          end
          op_table_read_current_page, op_table_read_last_page: begin
            mem_we <= 1'b1;
            mem_wdata <= rom_rdata[7:0];
            table_high_latch <= rom_rdata[15:8];
          end
          default: ;
        endcase
      end
    end
  end
  // table-read address: accumulator within current page or the last page
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rom_addr <= `PC_RESET;
    end else if (op == op_table_read_last_page) begin
      rom_addr <= {`LAST_PAGE, accumulator};
    end else begin
      rom_addr <= {program_counter[`PC_W-1:8], accumulator};
    end
  end
  // program counter and hardware stack
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      program_counter <= `PC_RESET;
      sp <= 3'h0;
      stack_overflow <= 1'b0;
      global_interrupt_enable <= 1'b0;
      for (int i = 0; i < `STACK_DEPTH; i++) stack[i] <= `PC_RESET;
    end else if (first_end) begin
      unique case (op)
        op_jump: program_counter <= target;
        op_call: begin
          stack[sp] <= program_counter + `PC_W'(1);
          program_counter <= target;
          if (sp == 3'(`STACK_DEPTH - 1)) stack_overflow <= 1'b1;
          else sp <= sp + 3'h1;
        end
        op_return, op_return_imm, op_return_from_interrupt: begin
          program_counter <= stack[sp - 3'h1];
          sp <= (sp == 3'h0) ? 3'h0 : sp - 3'h1;
          if (op == op_return_from_interrupt) global_interrupt_enable <= 1'b1;
        end
        op_nop: ;
        default: program_counter <= program_counter + `PC_W'(1);
      endcase
    end
  end
  // watchdog count and status flags
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      watchdog_counter <= `WDT_RESET;
      watchdog_timeout_flag <= 1'b0;
      power_down_flag <= 1'b0;
      preclear_first_seen <= 1'b0;
      preclear_second_seen <= 1'b0;
      prescaler_clear <= 1'b0;
      halted <= 1'b0;
    end else begin
      prescaler_clear <= 1'b0;
      halted <= (state == st_halted);
      if (first_end && op == op_clear_watchdog) begin
        watchdog_counter <= `WDT_RESET;
        watchdog_timeout_flag <= 1'b0;
        power_down_flag <= 1'b0;
      end else if (first_end && op == op_watchdog_preclear_first) begin
        if (preclear_second_seen) begin
          watchdog_counter <= `WDT_RESET;
          watchdog_timeout_flag <= 1'b0;
          power_down_flag <= 1'b0;
          preclear_second_seen <= 1'b0;
        end else preclear_first_seen <= 1'b1;
      end else if (first_end && op == op_watchdog_preclear_second) begin
        if (preclear_first_seen) begin
          watchdog_counter <= `WDT_RESET;
          watchdog_timeout_flag <= 1'b0;
          power_down_flag <= 1'b0;
          preclear_first_seen <= 1'b0;
        end else preclear_second_seen <= 1'b1;
      end else if (first_end && op == op_halt) begin
        watchdog_counter <= `WDT_RESET;
        prescaler_clear <= 1'b1;
        power_down_flag <= 1'b1;
        watchdog_timeout_flag <= 1'b0;
      end
    end
  end
  // assertions, all on the system clock and quiet during reset
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_call_two_cycles;
    (state == st_idle && start && instr_op == op_call) |-> ##9 (state == st_idle);
  endproperty
  a_call_two_cycles: assert property (p_call_two_cycles) else $error("call not 2 cycles");
  property p_halt_flags;
    (first_end && op == op_halt) |=> (power_down_flag && !watchdog_timeout_flag);
  endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");
  property p_and_keeps_carry;
    (first_end && op inside {op_and, op_and_imm, op_and_to_memory}) |=> $stable(carry_flag);
  endproperty
  a_and_keeps_carry: assert property (p_and_keeps_carry) else $error("and changed carry");
  property p_clear_writes_zero;
    (first_end && op == op_clear_byte) |=> (mem_we && mem_wdata == 8'h00);
  endproperty
  a_clear_writes_zero: assert property (p_clear_writes_zero) else $error("clear bad");
  property p_return_from_interrupt_enables;
    (first_end && op == op_return_from_interrupt) |=> global_interrupt_enable;
  endproperty
  a_return_from_interrupt_enables: assert property (p_return_from_interrupt_enables) else $error("enable not set");
  property p_skip_nop;
    (state == st_run && cycle_end && cycles_left == 2'h0 && is_skip_op && skip_taken)
      |=> (op == op_nop) [*4];
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("skip cycle not nop");
  property p_wdt_clear;
    (first_end && op == op_clear_watchdog) |=> (watchdog_counter == 8'h00 && !power_down_flag);
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared");
  property p_swap_acc_mem_untouched;
    (first_end && op == op_nibble_swap_to_accumulator) |=> !mem_we;
  endproperty
  a_swap_acc_mem_untouched: assert property (p_swap_acc_mem_untouched)
    else $error("swap wrote memory");
endmodule : mcu_branch_misc_exec

// ===== verification/mcu_mem_model.sv
// data memory and program memory model facing the execution core
`timescale 1ns/10ps
`include "mcu_exec_defines.svh"
module mcu_mem_model (
  input  wire logic             clk,
  input  wire logic [7:0]       mem_addr,
  input  wire logic [7:0]       mem_wdata,
  input  wire logic             mem_we,
  output logic [7:0]            mem_rdata,
  input  wire logic [`PC_W-1:0] rom_addr,
  output logic [15:0]           rom_rdata
);
  logic [7:0] ram [256];

  // known contents so a stray early read never carries unknowns into flags
  initial for (int i = 0; i < 256; i++) ram[i] = 8'h00;

  // write lands on the edge that samples the one-cycle strobe
  always @(posedge clk) begin
    if (mem_we) begin
      ram[mem_addr] <= mem_wdata;
    end
  end

  // read is combinational, same clock as the address
  assign mem_rdata = ram[mem_addr];
  // folded address: every word differs and only the high half depends on the page
  assign rom_rdata = {5'h15, rom_addr[10:8], rom_addr[7:0] ^ 8'h5a};
endmodule : mcu_mem_model

// ===== verification/testbench.sv
// self-checking bench for the branch, skip, table, clear, watchdog and add/and core
`timescale 1ns/10ps
`include "mcu_exec_defines.svh"
module testbench;
  import mcu_exec_pkg::*;
  logic             clk, reset, instr_valid, wake_up, mem_we, instr_ready;
  op_t              instr_op;
  logic [7:0]       instr_mem_addr, instr_imm, mem_rdata, mem_addr, mem_wdata;
  logic [7:0]       accumulator, table_high_latch, watchdog_counter;
  logic [2:0]       instr_bit;
  logic [`PC_W-1:0] instr_target, rom_addr, program_counter;
  logic [15:0]      rom_rdata;
  logic             overflow_flag, zero_flag, half_carry_flag, carry_flag;
  logic             watchdog_timeout_flag, power_down_flag, global_interrupt_enable;
  logic             prescaler_clear, halted, stack_overflow, pres_seen;
  int               error_cnt, cmp_count, cyc, cycle_cnt;

  mcu_branch_misc_exec dut_u (.clk(clk), .reset(reset), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_mem_addr(instr_mem_addr), .instr_bit(instr_bit),
    .instr_imm(instr_imm), .instr_target(instr_target), .mem_rdata(mem_rdata),
    .rom_rdata(rom_rdata), .wake_up(wake_up), .instr_ready(instr_ready),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .rom_addr(rom_addr),
    .program_counter(program_counter), .accumulator(accumulator),
    .table_high_latch(table_high_latch), .overflow_flag(overflow_flag),
    .zero_flag(zero_flag), .half_carry_flag(half_carry_flag), .carry_flag(carry_flag),
    .watchdog_timeout_flag(watchdog_timeout_flag), .power_down_flag(power_down_flag),
    .global_interrupt_enable(global_interrupt_enable),
    .watchdog_counter(watchdog_counter), .prescaler_clear(prescaler_clear),
    .halted(halted), .stack_overflow(stack_overflow));

  mcu_mem_model mem_u (.clk(clk), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata),
    .rom_addr(rom_addr), .rom_rdata(rom_rdata));

  // clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // hang guard; the whole run needs well under this many cycles
  always @(posedge clk) begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // one-cycle pulse would slip past a sampled check, so keep it sticky
  always @(posedge clk) begin
    if (prescaler_clear === 1'b1) pres_seen <= 1'b1;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // flags in the order overflow, zero, half carry, carry
  task automatic chkf(input logic [3:0] exp, input string msg);
    chk({overflow_flag, zero_flag, half_carry_flag, carry_flag}, exp, msg);
  endtask : chkf

  // preload only at a falling edge, away from the model's write edge
  task automatic poke(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    mem_u.ram[a] = v;
  endtask : poke

  // offer one operation, count cycles from the take edge until ready again
  task automatic run_op(input op_t o, input logic [7:0] a, input logic [2:0] b,
                        input logic [7:0] imm, input logic [`PC_W-1:0] tgt);
    int guard;
    guard = 0;
    @(negedge clk);
    while (instr_ready !== 1'b1 && guard < 40) begin
      @(negedge clk);
      guard++;
    end
    instr_valid = 1'b1;
    instr_op = o;
    instr_mem_addr = a;
    instr_bit = b;
    instr_imm = imm;
    instr_target = tgt;
    @(negedge clk);
    instr_valid = 1'b0;
    cyc = 1;
    while (instr_ready !== 1'b1 && cyc < 40) begin
      @(negedge clk);
      cyc++;
    end
    @(negedge clk); // the write strobe lands in the model one edge later
  endtask : run_op

  // every test variant, taken and untaken; skipped cycle touches nothing
  task automatic t_skips();
    op_t        o[6] = '{op_skip_if_zero, op_skip_if_zero, op_skip_if_bit_clear,
                         op_skip_if_bit_clear, op_skip_if_bit_set, op_skip_if_bit_set};
    logic [7:0] v[6] = '{8'h00, 8'h01, 8'hf7, 8'h08, 8'h80, 8'h7f};
    logic [2:0] b[6] = '{3'h0, 3'h0, 3'h3, 3'h3, 3'h7, 3'h7};
    for (int i = 0; i < 6; i++) begin
      poke(8'h40, v[i]);
      run_op(o[i], 8'h40, b[i], 8'h00, 11'h000);
      chk(16'(cyc), (i % 2 == 0) ? 16'h9 : 16'h5, "skip cycles");
      chk(mem_u.ram[8'h40], v[i], "tested byte kept");
    end
    poke(8'h41, 8'h00);
    run_op(op_skip_if_zero_move, 8'h41, 3'h0, 8'h00, 11'h000);
    chk(accumulator, 8'h00, "move zero");
    chk(16'(cyc), 16'h9, "move skip");
    poke(8'h41, 8'h5a);
    run_op(op_skip_if_zero_move, 8'h41, 3'h0, 8'h00, 11'h000);
    chk(accumulator, 8'h5a, "move byte");
    chk(16'(cyc), 16'h5, "move no skip");
  endtask : t_skips

  // memory and accumulator forms of increment/decrement with skip
  task automatic t_inc_dec();
    op_t        o[5] = '{op_increment_skip_zero, op_decrement_skip_zero,
                         op_decrement_skip_zero, op_increment_skip_zero_to_accumulator,
                         op_decrement_skip_zero_to_accumulator};
    logic [7:0] v[5] = '{8'hff, 8'h05, 8'h01, 8'hff, 8'h02};
    logic [7:0] r[5] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h01};
    for (int i = 0; i < 5; i++) begin
      poke(8'h42, v[i]);
      run_op(o[i], 8'h42, 3'h0, 8'h00, 11'h000);
      chk(16'(cyc), (r[i] == 8'h00) ? 16'h9 : 16'h5, "inc/dec cycles");
      if (i < 3) chk(mem_u.ram[8'h42], r[i], "inc/dec memory");
      else chk({accumulator, mem_u.ram[8'h42]}, {r[i], v[i]}, "inc/dec acc");
    end
  endtask : t_inc_dec

  // jump, nested calls and the three returns
  task automatic t_branch();
    logic [3:0] f;
    f = {overflow_flag, zero_flag, half_carry_flag, carry_flag};
    run_op(op_jump, 8'h00, 3'h0, 8'h00, 11'h123);
    chk(program_counter, 16'h0123, "jump target");
    chk(16'(cyc), 16'h9, "jump cycles");
    run_op(op_call, 8'h00, 3'h0, 8'h00, 11'h300);
    chk({program_counter, 5'(cyc)}, {11'h300, 5'h9}, "call");
    run_op(op_call, 8'h00, 3'h0, 8'h00, 11'h350);
    run_op(op_call, 8'h00, 3'h0, 8'h00, 11'h3a0);
    chkf(f, "call flags");
    run_op(op_return, 8'h00, 3'h0, 8'h00, 11'h000);
    chk({program_counter, 5'(cyc)}, {11'h351, 5'h9}, "return");
    run_op(op_return_imm, 8'h00, 3'h0, 8'h3c, 11'h000);
    chk(program_counter, 16'h0301, "return address");
    chk({accumulator, 8'(cyc)}, {8'h3c, 8'h9}, "return imm");
    run_op(op_return_from_interrupt, 8'h00, 3'h0, 8'h00, 11'h000);
    chk(program_counter, 16'h0124, "interrupt return");
    chk({global_interrupt_enable, 8'(cyc)}, {1'b1, 8'h9}, "enable set");
  endtask : t_branch

  // table reads from page 1 and the last page with accumulator 40
  task automatic t_table();
    run_op(op_jump, 8'h00, 3'h0, 8'h00, 11'h120);
    run_op(op_and_imm, 8'h00, 3'h0, 8'h00, 11'h000);
    run_op(op_add_imm, 8'h00, 3'h0, 8'h40, 11'h000);
    run_op(op_table_read_current_page, 8'h45, 3'h0, 8'h00, 11'h000);
    chk({table_high_latch, mem_u.ram[8'h45]}, 16'ha91a, "table current");
    chk(16'(cyc), 16'h9, "table cycles");
    run_op(op_table_read_last_page, 8'h46, 3'h0, 8'h00, 11'h000);
    chk({table_high_latch, mem_u.ram[8'h46]}, 16'haf1a, "table last");
  endtask : t_table

  // add and and flag effects, boundary sums for overflow and carries
  task automatic t_arith();
    run_op(op_and_imm, 8'h00, 3'h0, 8'h00, 11'h000);
    chk({accumulator, zero_flag}, {8'h00, 1'b1}, "and imm zero");
    run_op(op_add_imm, 8'h00, 3'h0, 8'h7f, 11'h000);
    run_op(op_add_imm, 8'h00, 3'h0, 8'h01, 11'h000);
    chk(accumulator, 8'h80, "add 7f+01");
    chkf(4'b1010, "flags 7f+01");
    run_op(op_add_imm, 8'h00, 3'h0, 8'h80, 11'h000);
    chk(accumulator, 8'h00, "add 80+80");
    chkf(4'b1101, "flags 80+80");
    poke(8'h47, 8'h0f);
    run_op(op_add_carry, 8'h47, 3'h0, 8'h00, 11'h000);
    chk(accumulator, 8'h10, "adc");
    chkf(4'b0010, "adc flags");
    poke(8'h48, 8'hf0);
    run_op(op_add_to_memory, 8'h48, 3'h0, 8'h00, 11'h000);
    chk({accumulator, mem_u.ram[8'h48]}, 16'h1000, "add to memory");
    chkf(4'b0101, "add to memory flags");
    poke(8'h49, 8'h30);
    run_op(op_and, 8'h49, 3'h0, 8'h00, 11'h000);
    chk(accumulator, 8'h10, "and memory");
    chkf(4'b0001, "and keeps carry");
    poke(8'h4a, 8'h0f);
    run_op(op_and_to_memory, 8'h4a, 3'h0, 8'h00, 11'h000);
    chk({accumulator, mem_u.ram[8'h4a]}, 16'h1000, "and to memory");
    chkf(4'b0101, "and to memory flags");
    poke(8'h4b, 8'h01);
    run_op(op_add_carry_to_memory, 8'h4b, 3'h0, 8'h00, 11'h000);
    chk({accumulator, mem_u.ram[8'h4b]}, 16'h1012, "adc to memory");
    chkf(4'b0000, "adc to memory flags");
  endtask : t_arith

  // clear, set and swap, then a write to the program counter low byte
  task automatic t_clear();
    poke(8'h50, 8'ha5);
    run_op(op_clear_byte, 8'h50, 3'h0, 8'h00, 11'h000);
    chk(mem_u.ram[8'h50], 8'h00, "clear byte");
    chkf(4'b0000, "clear flags");
    poke(8'h51, 8'hff);
    run_op(op_clear_bit, 8'h51, 3'h4, 8'h00, 11'h000);
    chk(mem_u.ram[8'h51], 8'hef, "clear bit");
    poke(8'h52, 8'h00);
    run_op(op_set_byte, 8'h52, 3'h0, 8'h00, 11'h000);
    chk(mem_u.ram[8'h52], 8'hff, "set byte");
    poke(8'h53, 8'h3c);
    run_op(op_swap, 8'h53, 3'h0, 8'h00, 11'h000);
    chk(mem_u.ram[8'h53], 8'hc3, "swap");
    poke(8'h54, 8'h12);
    run_op(op_nibble_swap_to_accumulator, 8'h54, 3'h0, 8'h00, 11'h000);
    chk({accumulator, mem_u.ram[8'h54]}, 16'h2112, "swap to acc");
    chk(16'(cyc), 16'h5, "swap to acc cycles");
    run_op(op_clear_byte, `PC_LOW_ADDR, 3'h0, 8'h00, 11'h000);
    chk(16'(cyc), 16'h9, "low byte write cycles");
  endtask : t_clear

  // halt before each: lone first, plain clear, second completes, lone second; then pair
  task automatic t_watchdog();
    op_t  w[4] = '{op_watchdog_preclear_first, op_clear_watchdog,
                   op_watchdog_preclear_second, op_watchdog_preclear_second};
    logic e[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    for (int k = 0; k < 4; k++) begin
      pres_seen = 1'b0;
      run_op(op_halt, 8'h00, 3'h0, 8'h00, 11'h000);
      chk({halted, power_down_flag, watchdog_timeout_flag}, 3'b110, "halt");
      chk({instr_ready, pres_seen}, 2'b01, "halt stops");
      wake_up = 1'b1;
      run_op(w[k], 8'h00, 3'h0, 8'h00, 11'h000);
      wake_up = 1'b0;
      chk(power_down_flag, e[k], "clear or preclear");
    end
    run_op(op_watchdog_preclear_first, 8'h00, 3'h0, 8'h00, 11'h000);
    chk({power_down_flag, watchdog_timeout_flag}, 2'b00, "pair clears");
  endtask : t_watchdog

  // reset, then the scenarios in turn
  initial begin
    reset = 1'b1;
    instr_valid = 1'b0;
    wake_up = 1'b0;
    instr_op = op_nop;
    instr_mem_addr = 8'h00;
    instr_bit = 3'h0;
    instr_imm = 8'h00;
    instr_target = 11'h000;
    pres_seen = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    cycle_cnt = 0;
    repeat (10) @(negedge clk);
    chk({accumulator, instr_ready, mem_we}, 10'h000, "outputs in reset");
    chk(program_counter, `PC_RESET, "pc in reset");
    reset = 1'b0;
    t_skips();
    t_inc_dec();
    t_branch();
    t_table();
    t_arith();
    t_clear();
    t_watchdog();
    report_and_stop();
  end
endmodule : testbench
